/* common/pc_seq_consts.svh */
`ifndef PC_SEQ_CONSTS_SVH
`define PC_SEQ_CONSTS_SVH

// program counter geometry
`define PC_W 13
`define PC_LOW_W 8
`define PC_UPPER_W 5
`define LATCH_W 5
`define JUMP_W 11
`define PAGE_W 2
`define PAGE_LSB 3

// return stack geometry
`define STACK_DEPTH 8

// reset and vector values
`define PC_RESET 13'h0000
`define LATCH_RESET 5'h00
`define VECTOR_ADDR 13'h0004

`endif

/* common/pc_seq_pkg.sv */
`include "pc_seq_consts.svh"

package pc_seq_pkg;

    // sequencing action requested by decode for this cycle
    typedef enum logic [3:0] {
        OP_HOLD,
        OP_STEP,
        OP_JUMP,
        OP_CALL,
        OP_RETURN,
        OP_RETURN_LITERAL,
        OP_RETURN_INTERRUPT,
        OP_VECTOR,
        OP_WRITE_LOW
    } pc_op_e;

    typedef logic [`PC_W-1:0] pc_addr_t;
    typedef logic [`LATCH_W-1:0] latch_t;

    // one command from the execute stage
    typedef struct packed {
        pc_op_e op;
        logic [`JUMP_W-1:0] target;
        logic [`PC_LOW_W-1:0] low_data;
    } pc_cmd_s;

    // software write to pc_high_latch
    typedef struct packed {
        logic we;
        latch_t data;
    } latch_wr_s;

endpackage

/* hdl/program_counter_stack_paging.sv */
`timescale 1ns/1ps
// Function
// - 13-bit counter, low byte readable and writable
// - upper bits hidden, no direct write; set from latch, stack or branch
// - any reset clears the upper counter bits
// - low-byte write loads upper bits from latch
// - call/jump: 11 instruction bits, latch page bits
// - eight-deep 13-bit stack, pointer hidden
// - push on call and interrupt vectoring
// - pop on the three return kinds
// - push and pop never touch the latch
// - stack wraps circularly, oldest entry overwritten
// - no overflow or underflow indication
// - 8K word space in 2K pages
// - return restores whole counter from stack
`include "pc_seq_consts.svh"

module program_counter_stack_paging
    import pc_seq_pkg::*;
#(
    parameter int STACK_DEPTH = `STACK_DEPTH,
    parameter pc_addr_t VECTOR_ADDR = `VECTOR_ADDR
) (
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic resetn_i,
    // command from decode and execute
    input wire pc_cmd_s cmd_i,
    // software write of pc_high_latch
    input wire latch_wr_s latch_wr_i,
    // fetch address and software-visible views
    output logic [`PC_W-1:0] pc_o,
    output logic [`PC_LOW_W-1:0] pc_low_byte_reg_o,
    output logic [`LATCH_W-1:0] pc_high_latch_o
);

    localparam int PTR_W = $clog2(STACK_DEPTH);

    // the pointer wraps by plain overflow, so only powers of two are served
    if (STACK_DEPTH < 2 || (1 << PTR_W) != STACK_DEPTH) begin : g_bad_depth
        $error("STACK_DEPTH must be a power of two, at least 2");
    end

    // counter, latch and stack state
    pc_addr_t pc;
    pc_addr_t next_pc;
    latch_t pc_high_latch;
    latch_t next_pc_high_latch;
    pc_addr_t stack [STACK_DEPTH];
    pc_addr_t next_stack [STACK_DEPTH];
    logic [PTR_W-1:0] sp;
    logic [PTR_W-1:0] next_sp;

    // decoded stack actions
    logic push;
    logic pop;
    pc_addr_t push_value;
    logic [PTR_W-1:0] top;

    // stack action decode; returns of every kind share one pop path
    always_comb begin
        push = 1'b0;
        pop = 1'b0;
        push_value = pc;
        case (cmd_i.op)
            OP_CALL: begin
                push = 1'b1;
                push_value = pc + 13'h0001; // resume after the call
            end
            OP_VECTOR: begin
                push = 1'b1;
                push_value = pc; // interrupted instruction has not run
            end
            OP_RETURN, OP_RETURN_LITERAL, OP_RETURN_INTERRUPT: begin
                pop = 1'b1;
            end
            default: begin
                push = 1'b0;
                pop = 1'b0;
            end
        endcase
    end

    // entry below the pointer is the most recent push
    assign top = sp - {{(PTR_W-1){1'b0}}, 1'b1};

    // next program counter
    always_comb begin
        next_pc = pc;
        case (cmd_i.op)
            OP_HOLD: begin
                next_pc = pc;
            end
            OP_STEP: begin
                next_pc = pc + 13'h0001; // wraps at 8K words
            end
            OP_JUMP, OP_CALL: begin
                // page bits from the latch, offset from the opcode
                next_pc = {pc_high_latch[`PAGE_LSB +: `PAGE_W], cmd_i.target};
            end
            OP_RETURN, OP_RETURN_LITERAL, OP_RETURN_INTERRUPT: begin
                next_pc = stack[top]; // latch page bits ignored
            end
            OP_VECTOR: begin
                next_pc = VECTOR_ADDR;
            end
            OP_WRITE_LOW: begin
                // computed jumps land here too; no carry into the upper bits
                next_pc = {pc_high_latch, cmd_i.low_data};
            end
            default: begin
                next_pc = pc;
            end
        endcase
    end

    // latch moves only on a software write, never on stack traffic
    always_comb begin
        next_pc_high_latch = pc_high_latch;
        if (latch_wr_i.we) begin
            next_pc_high_latch = latch_wr_i.data;
        end
    end

    // stack: pointer wraps silently, so a ninth push lands on the first slot
    always_comb begin
        for (int i = 0; i < STACK_DEPTH; i++) begin
            next_stack[i] = stack[i];
        end
        next_sp = sp;
        if (push) begin
            next_stack[sp] = push_value;
            next_sp = sp + {{(PTR_W-1){1'b0}}, 1'b1};
        end else if (pop) begin
            next_sp = top; // underflow wraps without a flag
        end
    end

    // state registers; stack contents are cleared too, for clean reruns
    always_ff @(posedge ref_clk_i) begin
        if (!resetn_i) begin
            pc <= `PC_RESET;
            pc_high_latch <= `LATCH_RESET;
            sp <= '0;
            for (int i = 0; i < STACK_DEPTH; i++) begin
                stack[i] <= `PC_RESET;
            end
        end else begin
            pc <= next_pc;
            pc_high_latch <= next_pc_high_latch;
            sp <= next_sp;
            for (int i = 0; i < STACK_DEPTH; i++) begin
                stack[i] <= next_stack[i];
            end
        end
    end

    // outputs come straight from the registers
    assign pc_o = pc;
    assign pc_low_byte_reg_o = pc[`PC_LOW_W-1:0];
    assign pc_high_latch_o = pc_high_latch;

    // checks on the sequencing behaviour
    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (!resetn_i);

    // reset clears the upper counter bits
    property p_reset_clear;
        disable iff (1'b0)
        !resetn_i |=> (pc[`PC_W-1:`PC_LOW_W] == 5'h00);
    endproperty
    a_reset_clear: assert property (p_reset_clear)
        else $error("upper counter bits not cleared by reset");

    // sequential step adds exactly one
    property p_step;
        (cmd_i.op == OP_STEP) |=> (pc == pc_addr_t'($past(pc) + 13'h0001));
    endproperty
    a_step: assert property (p_step)
        else $error("step did not advance counter by one");

    // stepping off the top of the space lands on zero
    property p_step_wrap;
        (cmd_i.op == OP_STEP) && (pc == 13'h1fff) |=> (pc == 13'h0000);
    endproperty
    a_step_wrap: assert property (p_step_wrap)
        else $error("step did not wrap at the top of the space");

    // low-byte write merges the whole latch
    property p_write_low;
        (cmd_i.op == OP_WRITE_LOW)
            |=> (pc == {$past(pc_high_latch), $past(cmd_i.low_data)});
    endproperty
    a_write_low: assert property (p_write_low)
        else $error("low-byte write did not load upper bits from latch");

    // the software view shows the written low byte
    property p_low_view;
        (cmd_i.op == OP_WRITE_LOW) |=> (pc_low_byte_reg_o == $past(cmd_i.low_data));
    endproperty
    a_low_view: assert property (p_low_view)
        else $error("low byte view does not show the written value");

    // jump and call take page bits from the latch
    property p_branch_page;
        (cmd_i.op inside {OP_JUMP, OP_CALL})
            |=> (pc[`PC_W-1:`JUMP_W] == $past(pc_high_latch[`PAGE_LSB +: `PAGE_W]))
                && (pc[`JUMP_W-1:0] == $past(cmd_i.target));
    endproperty
    a_branch_page: assert property (p_branch_page)
        else $error("branch target or page bits wrong");

    // a call followed at once by a return lands after the call
    property p_call_return;
        (cmd_i.op == OP_CALL) ##1 (cmd_i.op inside {OP_RETURN, OP_RETURN_LITERAL})
            |=> (pc == pc_addr_t'($past(pc, 2) + 13'h0001));
    endproperty
    a_call_return: assert property (p_call_return)
        else $error("return did not restore the pushed address");

    // vectoring then returning resumes at the interrupted address
    property p_vector_return;
        (cmd_i.op == OP_VECTOR) ##1 (cmd_i.op == OP_RETURN_INTERRUPT)
            |=> (pc == $past(pc, 2));
    endproperty
    a_vector_return: assert property (p_vector_return)
        else $error("interrupt return did not resume interrupted address");

    // vectoring reaches the vector in one cycle
    property p_vector;
        (cmd_i.op == OP_VECTOR) |=> (pc == VECTOR_ADDR);
    endproperty
    a_vector: assert property (p_vector)
        else $error("vectoring did not reach the vector address");

    // a call leaves the address after itself on top of the stack
    property p_call_push;
        (cmd_i.op == OP_CALL) |=> (stack[top] == pc_addr_t'($past(pc) + 13'h0001));
    endproperty
    a_call_push: assert property (p_call_push)
        else $error("call did not push the return address");

    // vectoring leaves the interrupted address on top of the stack
    property p_vector_push;
        (cmd_i.op == OP_VECTOR) |=> (stack[top] == $past(pc));
    endproperty
    a_vector_push: assert property (p_vector_push)
        else $error("vectoring did not push the interrupted address");

    // every return loads the whole counter from the top entry
    property p_return_pops;
        pop |=> (pc == $past(stack[top]));
    endproperty
    a_return_pops: assert property (p_return_pops)
        else $error("return did not load the counter from the stack");

    // a software write lands in the latch one cycle later
    property p_latch_write;
        latch_wr_i.we |=> (pc_high_latch == $past(latch_wr_i.data));
    endproperty
    a_latch_write: assert property (p_latch_write)
        else $error("latch write did not land");

    // nothing but a software write moves the latch
    property p_latch_only_written;
        !latch_wr_i.we |=> $stable(pc_high_latch);
    endproperty
    a_latch_only_written: assert property (p_latch_only_written)
        else $error("latch moved without a software write");

    // every push steps the pointer forward by one, wrapping silently
    property p_push_ptr;
        push |=> (sp == PTR_W'($past(sp) + 1));
    endproperty
    a_push_ptr: assert property (p_push_ptr)
        else $error("push did not step the pointer forward");

    // stack traffic leaves the latch alone
    property p_latch_kept;
        (push || pop) && !latch_wr_i.we |=> $stable(pc_high_latch);
    endproperty
    a_latch_kept: assert property (p_latch_kept)
        else $error("latch changed on push or pop");

    // pointer wraps from the last slot to the first
    property p_wrap;
        push && (sp == PTR_W'(STACK_DEPTH - 1)) |=> (sp == '0);
    endproperty
    a_wrap: assert property (p_wrap)
        else $error("stack pointer did not wrap on push");

    // every pop steps the pointer back by one
    property p_pop_ptr;
        pop |=> (sp == PTR_W'($past(sp) - 1));
    endproperty
    a_pop_ptr: assert property (p_pop_ptr)
        else $error("pop did not step the pointer back");

    // a second hold in a row keeps the counter still
    property p_hold;
        (cmd_i.op == OP_HOLD) [*2] |=> $stable(pc);
    endproperty
    a_hold: assert property (p_hold)
        else $error("counter moved while held");

endmodule

/* dv/exec_model.sv */
`timescale 1ns/1ps
module exec_model
    import pc_seq_pkg::*;
(
    // clock
    input wire logic ref_clk_i,
    // command and latch write toward the sequencer
    output pc_cmd_s cmd_o,
    output latch_wr_s latch_wr_o
);
    // idle until the bench asks for work
    initial begin
        cmd_o = '{op: OP_HOLD, target: 11'h000, low_data: 8'h00};
        latch_wr_o = '{we: 1'b0, data: 5'h00};
    end

    // one command, then a hold cycle so two calls never assign in one step
    task automatic issue(input pc_op_e op, input logic [10:0] tgt, input logic [7:0] low);
        @(negedge ref_clk_i);
        cmd_o = '{op: op, target: tgt, low_data: low};
        @(negedge ref_clk_i);
        cmd_o.op = OP_HOLD;
    endtask

    // two commands on consecutive edges, then a hold cycle
    task automatic issue_pair(input pc_op_e op_a, input logic [10:0] tgt, input pc_op_e op_b);
        @(negedge ref_clk_i);
        cmd_o = '{op: op_a, target: tgt, low_data: 8'h00};
        @(negedge ref_clk_i);
        cmd_o.op = op_b;
        @(negedge ref_clk_i);
        cmd_o.op = OP_HOLD;
    endtask

    // page is written ahead of a run of branches and not again after returns, since returns leave it alone
    task automatic set_latch(input logic [4:0] data);
        @(negedge ref_clk_i);
        latch_wr_o = '{we: 1'b1, data: data};
        @(negedge ref_clk_i);
        latch_wr_o.we = 1'b0;
    endtask
endmodule

/* dv/program_counter_stack_paging_bench.sv */
`timescale 1ns/1ps
module program_counter_stack_paging_bench;
    import pc_seq_pkg::*;
    logic ref_clk_i = 1'b0;
    logic resetn_i = 1'b0;
    pc_cmd_s cmd;
    latch_wr_s latch_wr;
    logic [12:0] pc;
    logic [7:0] pc_low;
    logic [4:0] latch;
    int fail_count = 0;
    int tests_run = 0;
    logic [12:0] ref_stack [8];
    int sp = 0;
    logic [12:0] exp_pc = 13'h0000;

    // 200 MHz core clock
    always #2.5 ref_clk_i = ~ref_clk_i;

    exec_model u_exec (.ref_clk_i(ref_clk_i), .cmd_o(cmd), .latch_wr_o(latch_wr));

    program_counter_stack_paging u_dut (
        .ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .cmd_i(cmd), .latch_wr_i(latch_wr),
        .pc_o(pc), .pc_low_byte_reg_o(pc_low), .pc_high_latch_o(latch));

    task automatic check(input logic [12:0] seen, input logic [12:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fail_count++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic tally_and_finish();
        $display("checks %0d, mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask

    // reused mid-run to show a second reset clears the counter again
    task automatic test_reset();
        @(negedge ref_clk_i);
        resetn_i = 1'b0;
        repeat (20) @(negedge ref_clk_i);
        check(pc, 13'h0000);
        check({5'h00, pc_low}, 13'h0000);
        check({8'h00, latch}, 13'h0000);
        resetn_i = 1'b1;
        exp_pc = 13'h0000;
        sp = 0;
    endtask

    task automatic test_write_low();
        u_exec.set_latch(5'h1a);
        u_exec.issue(OP_WRITE_LOW, 11'h000, 8'h3c);
        check(pc, 13'h1a3c);
        check({5'h00, pc_low}, 13'h003c);
    endtask

    // every page, with junk in the low latch bits that must be ignored
    task automatic test_jump();
        for (int p = 0; p < 4; p++) begin
            u_exec.set_latch({p[1:0], 3'h5});
            u_exec.issue(OP_JUMP, 11'h7f1, 8'h00);
            exp_pc = {p[1:0], 11'h7f1};
            check(pc, exp_pc);
        end
    endtask

    // runs off the top of the 8K space
    task automatic test_step();
        for (int i = 0; i < 15; i++) begin
            u_exec.issue(OP_STEP, 11'h000, 8'h00);
            exp_pc = exp_pc + 13'h0001;
            check(pc, exp_pc);
        end
    endtask

    // ten calls overrun the ring, then nine mixed returns walk back and wrap
    task automatic test_stack();
        pc_op_e ret_ops [3];
        ret_ops = '{OP_RETURN, OP_RETURN_LITERAL, OP_RETURN_INTERRUPT};
        u_exec.set_latch(5'h10);
        for (int i = 0; i < 10; i++) begin
            ref_stack[sp] = exp_pc + 13'h0001;
            sp = (sp + 1) % 8;
            u_exec.issue(OP_CALL, 11'h100 + 11'(i * 5), 8'h00);
            exp_pc = {2'b10, 11'h100 + 11'(i * 5)};
            check(pc, exp_pc);
        end
        for (int j = 0; j < 9; j++) begin
            sp = (sp + 7) % 8;
            exp_pc = ref_stack[sp];
            u_exec.issue(ret_ops[j % 3], 11'h7ff, 8'h00);
            check(pc, exp_pc);
            check({8'h00, latch}, 13'h0010);
        end
    endtask

    // vectoring saves the unexecuted address itself
    task automatic test_vector();
        logic [12:0] saved;
        saved = exp_pc;
        u_exec.issue(OP_VECTOR, 11'h000, 8'h00);
        check(pc, 13'h0004);
        u_exec.issue(OP_RETURN_INTERRUPT, 11'h000, 8'h00);
        check(pc, saved);
    endtask

    // return straight after call, and after vectoring, with no idle edge between
    task automatic test_back_to_back();
        u_exec.set_latch(5'h08);
        exp_pc = pc + 13'h0001;
        u_exec.issue_pair(OP_CALL, 11'h123, OP_RETURN_LITERAL);
        check(pc, exp_pc);
        u_exec.issue_pair(OP_VECTOR, 11'h000, OP_RETURN_INTERRUPT);
        check(pc, exp_pc);
        check({8'h00, latch}, 13'h0008);
    endtask

    // main sequence
    initial begin
        test_reset();
        test_write_low();
        test_jump();
        test_step();
        test_stack();
        test_vector();
        test_back_to_back();
        test_write_low();
        test_reset();
        test_jump();
        tally_and_finish();
    end

    // the whole run needs under a microsecond; far longer means a hang
    initial begin
        #20000;
        fail_count++;
        tally_and_finish();
    end
endmodule
